// File: rtl/ebac_pkg.sv
// ebac_pkg: constants for the external bus area controller.
// assumes a 20-bit address space and 200 MHz mclk.
`default_nettype none
package ebac_pkg;
    localparam int ADDR_W = 20;
    localparam int BND_W  = 21;
    // register byte offsets on the ahb-lite slave
    localparam logic [7:0] OFS_BYTE_BND = 8'h00;
    localparam logic [7:0] OFS_SLOW_BND = 8'h04;
    localparam logic [7:0] OFS_BUS_CTL  = 8'h08;
    localparam logic [7:0] OFS_RAM_EN   = 8'h0c;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    // bus_ctl_reg fields
    localparam int CTL_AREA_ON = 7;
    localparam int CTL_ZP_SLOW = 6;
    localparam int CTL_RSV_ONE = 5;
    localparam int CTL_PORT_W  = 5;
    localparam logic [7:0] CTL_RST_ON  = 8'h9f;
    localparam logic [7:0] CTL_RST_OFF = 8'h1f;
    // operating modes
    localparam logic [2:0] MODE1 = 3'h1;
    localparam logic [2:0] MODE2 = 3'h2;
    localparam logic [2:0] MODE3 = 3'h3;
    localparam logic [2:0] MODE4 = 3'h4;
    localparam logic [2:0] MODE5 = 3'h5;
    localparam logic [2:0] MODE6 = 3'h6;
    localparam logic [2:0] MODE7 = 3'h7;
    // boundary reset values; 21'h100000 means no such area
    localparam logic [BND_W-1:0] BND_NONE   = 21'h100000;
    localparam logic [BND_W-1:0] BND_ZERO   = 21'h000000;
    localparam logic [BND_W-1:0] SLOW_RST_1 = 21'h00ee00;
    localparam logic [BND_W-1:0] SLOW_RST_2 = 21'h00ee80;
    localparam logic [BND_W-1:0] BYTE_RST_2 = 21'h00ee80;
    localparam logic [BND_W-1:0] SLOW_RST_3 = 21'h00e000;
    localparam logic [BND_W-1:0] SLOW_RST_4 = 21'h00ee80;
    // on-chip regions within page 0
    localparam logic [15:0] ROM_LAST = 16'hee7f;
    localparam logic [15:0] RAM_BASE = 16'hf680;
    localparam logic [15:0] RAM_LAST = 16'hfe7f;
    localparam logic [15:0] IO_BASE  = 16'hfe80;
    // first address of each 4-byte port block, one per control bit 0..4
    localparam logic [15:0] PORT_BASE [CTL_PORT_W] =
        '{16'hfe80, 16'hfe94, 16'hfe98, 16'hfe9c, 16'hfe90};
    // bus states: a two-state cycle is T1,T2; three-state adds T3
    localparam int CLK_MHZ   = 200;
    localparam int T_STATE_NS = 5;
    localparam int STATE_CYC  = (T_STATE_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [1:0] {ST_IDLE, ST_T1, ST_T2, ST_T3} ebac_st_type;
endpackage
`default_nettype wire

// File: rtl/ebac_area_decode.sv
// ebac_area_decode: per-address width and cycle length decision.
// assumes a masked address and settled control registers.
`default_nettype none
module ebac_area_decode
    import ebac_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [2:0]        mode,
    input  wire logic [BND_W-1:0]  byte_bnd,
    input  wire logic [BND_W-1:0]  slow_bnd,
    input  wire logic [7:0]        ctl,
    input  wire logic              ram_en,
    output logic                   ext,
    output logic                   wide,
    output logic                   slow
);
    logic                  page0;
    logic                  in_io;
    logic                  in_ram;
    logic                  in_rom;
    logic [CTL_PORT_W-1:0] fall;
    logic                  any_fall;
    logic                  byte_area;
    logic                  narrow;

    assign page0 = (addr[19:16] == 4'h0);
    assign in_io = page0 && (addr[15:0] >= IO_BASE);
    assign in_ram = ram_en && page0 && (addr[15:0] >= RAM_BASE)
                    && (addr[15:0] <= RAM_LAST);
    assign in_rom = (mode == MODE2 || mode == MODE4 || mode == MODE7)
                    && page0 && (addr[15:0] <= ROM_LAST);

    // cleared port bit: its block falls through to external space
    for (genvar i = 0; i < CTL_PORT_W; i++) begin : g_port
        assign fall[i] = in_io && !ctl[i]
                         && (addr[15:2] == PORT_BASE[i][15:2]);
    end
    assign any_fall = |fall;

    // ram and rom are internal, always wide two-state
    assign ext = (mode != MODE7) && !in_ram && !in_rom
                 && !(in_io && !any_fall);
    // word area below the byte boundary, byte area from it upward
    assign byte_area = ({1'b0, addr} >= byte_bnd);
    assign narrow = !ctl[CTL_AREA_ON] || any_fall || (mode == MODE2)
                    || byte_area;

    always_comb begin
        wide = 1'b1;
        slow = 1'b0;
        if (ext) begin
            wide = !narrow;
            // no eight-bit two-state area exists
            slow = narrow || ({1'b0, addr} >= slow_bnd)
                   || (ctl[CTL_ZP_SLOW] && page0);
        end
    end
endmodule
`default_nettype wire

// File: rtl/ebac_lane_map.sv
// ebac_lane_map: data lane enables and active-low strobes.
// assumes attributes latched for the whole bus cycle.
`default_nettype none
module ebac_lane_map (
    input  wire logic busy,
    input  wire logic strobe_ph,
    input  wire logic write,
    input  wire logic wide,
    input  wire logic word,
    input  wire logic a0,
    output logic      hi_oe,
    output logic      lo_oe,
    output logic      rd_n,
    output logic      hwr_n,
    output logic      lwr_n
);
    logic wr_ph;
    logic hi_sel;
    logic lo_sel;

    assign wr_ph = strobe_ph && write;
    assign hi_sel = !wide || word || !a0;
    assign lo_sel = wide && (word || a0);
    // wide writes also drive the unused lane with dummy data
    assign hi_oe = busy && write;
    assign lo_oe = busy && write && wide;
    assign rd_n  = !(strobe_ph && !write);
    assign hwr_n = !(wr_ph && hi_sel);
    assign lwr_n = !(wr_ph && lo_sel);
endmodule
`default_nettype wire

// File: rtl/ebac_ctl.sv
// ebac_ctl: external bus area controller with ahb-lite registers.
// assumes cpu_req is held until cpu_done and the mode strap is stable.
`default_nettype none
module ebac_ctl
    import ebac_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [2:0]        mode,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic              cpu_req,
    input  wire logic [ADDR_W-1:0] cpu_addr,
    input  wire logic              cpu_word,
    input  wire logic              cpu_write,
    input  wire logic [15:0]       cpu_wdata,
    output logic                   cpu_done,
    output logic                   cpu_ext,
    output logic [15:0]            cpu_rdata,
    output logic [ADDR_W-1:0]      ext_addr,
    output logic [7:0]             data_hi_out,
    output logic                   data_hi_oe,
    output logic [7:0]             data_lo_out,
    output logic                   data_lo_oe,
    input  wire logic [15:0]       data_in,
    output logic                   rd_n,
    output logic                   high_byte_write_strobe_n,
    output logic                   low_byte_write_strobe_n
);
    ////////////////////////////////////////////////////////////////////
    logic             init_r, init_nxt;
    logic [2:0]       mode_r, mode_nxt;
    logic [BND_W-1:0] byte_bnd_r, byte_bnd_nxt;
    logic [BND_W-1:0] slow_bnd_r, slow_bnd_nxt;
    logic [7:0]       ctl_r, ctl_nxt;
    logic             ram_en_r, ram_en_nxt;
    logic             wr_pend_r, wr_pend_nxt;
    logic             rd_pend_r, rd_pend_nxt;
    logic [7:0]       ofs_r, ofs_nxt;
    logic [31:0]      rdata_r, rdata_nxt;
    logic             mode56;
    logic [31:0]      rd_val;

    assign mode56 = (mode_r == MODE5) || (mode_r == MODE6);
    // registers answer only after the strap is caught; a read waits
    // one state so that hrdata comes straight from a flop
    assign hreadyout = init_r && !rd_pend_r;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;

    always_comb begin
        unique case (ofs_r)
            OFS_BYTE_BND: rd_val = {11'h0, byte_bnd_r};
            OFS_SLOW_BND: rd_val = {11'h0, slow_bnd_r};
            OFS_BUS_CTL:  rd_val = {24'h0, ctl_r | 8'h20};
            OFS_RAM_EN:   rd_val = {31'h0, ram_en_r};
            OFS_STATUS:   rd_val = {23'h0, cpu_ext, 5'h0, mode_r};
            default:      rd_val = 32'h0;
        endcase
    end

    always_comb begin
        init_nxt = 1'b1;
        mode_nxt = mode_r;
        byte_bnd_nxt = byte_bnd_r;
        slow_bnd_nxt = slow_bnd_r;
        ctl_nxt = ctl_r;
        ram_en_nxt = ram_en_r;
        rdata_nxt = rdata_r;
        wr_pend_nxt = wr_pend_r;
        rd_pend_nxt = rd_pend_r;
        ofs_nxt = ofs_r;
        if (!init_r) begin
            // mode-dependent reset map caught after release
            mode_nxt = mode;
            ctl_nxt = CTL_RST_ON;
            byte_bnd_nxt = BND_NONE;
            slow_bnd_nxt = BND_NONE;
            unique case (mode)
                MODE1: slow_bnd_nxt = SLOW_RST_1;
                MODE2: begin
                    slow_bnd_nxt = SLOW_RST_2;
                    byte_bnd_nxt = BYTE_RST_2;
                end
                MODE3: slow_bnd_nxt = SLOW_RST_3;
                MODE4: slow_bnd_nxt = SLOW_RST_4;
                MODE5, MODE6: begin
                    ctl_nxt = CTL_RST_OFF;
                    byte_bnd_nxt = BND_ZERO;
                    slow_bnd_nxt = BND_ZERO;
                end
                default: ;
            endcase
        end else begin
            if (wr_pend_r) begin
                unique case (ofs_r)
                    OFS_BYTE_BND: byte_bnd_nxt = hwdata[BND_W-1:0];
                    OFS_SLOW_BND: slow_bnd_nxt = hwdata[BND_W-1:0];
                    OFS_BUS_CTL: begin
                        ctl_nxt = hwdata[7:0];
                        ctl_nxt[CTL_AREA_ON] = hwdata[CTL_AREA_ON] || !mode56;
                        if (mode_r == MODE7)
                            ctl_nxt[4:0] = 5'h1f;
                    end
                    OFS_RAM_EN:   ram_en_nxt = hwdata[0];
                    default: ;
                endcase
            end
            if (rd_pend_r) begin
                rdata_nxt = rd_val;
                rd_pend_nxt = 1'b0;
            end
            if (hready) begin
                wr_pend_nxt = hsel && htrans[1] && hwrite;
                rd_pend_nxt = hsel && htrans[1] && !hwrite;
                ofs_nxt = haddr[7:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            init_r <= 1'b0;
            mode_r <= MODE7;
            byte_bnd_r <= BND_NONE;
            slow_bnd_r <= BND_NONE;
            ctl_r <= CTL_RST_ON;
            ram_en_r <= 1'b1;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            ofs_r <= 8'h00;
            rdata_r <= 32'h0;
        end else begin
            init_r <= init_nxt;
            mode_r <= mode_nxt;
            byte_bnd_r <= byte_bnd_nxt;
            slow_bnd_r <= slow_bnd_nxt;
            ctl_r <= ctl_nxt;
            ram_en_r <= ram_en_nxt;
            wr_pend_r <= wr_pend_nxt;
            rd_pend_r <= rd_pend_nxt;
            ofs_r <= ofs_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus cycle engine
    ebac_st_type      st_r, st_nxt;
    logic             cyc_wide_r, cyc_wide_nxt;
    logic             cyc_slow_r, cyc_slow_nxt;
    logic             cyc_word_r, cyc_word_nxt;
    logic             cyc_wr_r, cyc_wr_nxt;
    logic             split_r, split_nxt;
    logic             done_r, done_nxt;
    logic             ext_r, ext_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [7:0]       dhi_r, dhi_nxt;
    logic [7:0]       dlo_r, dlo_nxt;
    logic [15:0]      rdat_r, rdat_nxt;
    logic [ADDR_W-1:0] req_addr;
    logic             dec_ext, dec_wide, dec_slow;
    logic             last_st;
    logic             start;

    // 64k modes ignore the page bits
    assign req_addr = (mode_r == MODE3 || mode_r == MODE4 || mode_r == MODE5)
                      ? cpu_addr : {4'h0, cpu_addr[15:0]};

    ebac_area_decode u_dec (
        .addr     (req_addr),
        .mode     (mode_r),
        .byte_bnd (byte_bnd_r),
        .slow_bnd (slow_bnd_r),
        .ctl      (ctl_r),
        .ram_en   (ram_en_r),
        .ext      (dec_ext),
        .wide     (dec_wide),
        .slow     (dec_slow)
    );

    assign start = init_r && cpu_req && !done_r && (st_r == ST_IDLE);
    assign last_st = (st_r == ST_T3) || (st_r == ST_T2 && !cyc_slow_r);

    always_comb begin
        st_nxt = st_r;
        cyc_wide_nxt = cyc_wide_r;
        cyc_slow_nxt = cyc_slow_r;
        cyc_word_nxt = cyc_word_r;
        cyc_wr_nxt = cyc_wr_r;
        split_nxt = split_r;
        addr_nxt = addr_r;
        dhi_nxt = dhi_r;
        dlo_nxt = dlo_r;
        rdat_nxt = rdat_r;
        ext_nxt = ext_r;
        done_nxt = 1'b0;
        if (start) begin
            ext_nxt = dec_ext;
            if (!dec_ext) begin
                // on-chip targets are served elsewhere
                done_nxt = 1'b1;
                rdat_nxt = 16'h0;
            end else begin
                st_nxt = ST_T1;
                addr_nxt = req_addr;
                // attributes frozen for the cycle
                cyc_wide_nxt = dec_wide;
                cyc_slow_nxt = dec_slow;
                cyc_word_nxt = cpu_word;
                cyc_wr_nxt = cpu_write;
                split_nxt = cpu_word && !dec_wide;
                if (cpu_word) begin
                    dhi_nxt = cpu_wdata[15:8];
                    dlo_nxt = cpu_wdata[7:0];
                end else begin
                    dhi_nxt = cpu_wdata[7:0];
                    dlo_nxt = cpu_wdata[7:0];
                end
            end
        end else begin
            unique case (st_r)
                ST_IDLE: ;
                ST_T1: st_nxt = ST_T2;
                ST_T2: if (cyc_slow_r) st_nxt = ST_T3;
                ST_T3: ;
            endcase
            if (last_st) begin
                if (!cyc_wr_r) begin
                    if (cyc_wide_r && cyc_word_r)
                        rdat_nxt = data_in;
                    else if (split_r)
                        rdat_nxt = {data_in[15:8], 8'h00};
                    else if (cyc_word_r)
                        rdat_nxt = {rdat_r[15:8], data_in[15:8]};
                    else if (cyc_wide_r && addr_r[0])
                        rdat_nxt = {8'h00, data_in[7:0]};
                    else
                        rdat_nxt = {8'h00, data_in[15:8]};
                end
                if (split_r) begin
                    // odd byte follows the even one
                    st_nxt = ST_T1;
                    split_nxt = 1'b0;
                    addr_nxt = {addr_r[ADDR_W-1:1], 1'b1};
                    dhi_nxt = dlo_r;
                end else begin
                    st_nxt = ST_IDLE;
                    done_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            cyc_wide_r <= 1'b1;
            cyc_slow_r <= 1'b0;
            cyc_word_r <= 1'b0;
            cyc_wr_r <= 1'b0;
            split_r <= 1'b0;
            done_r <= 1'b0;
            ext_r <= 1'b0;
            addr_r <= '0;
            dhi_r <= 8'h00;
            dlo_r <= 8'h00;
            rdat_r <= 16'h0;
        end else begin
            st_r <= st_nxt;
            cyc_wide_r <= cyc_wide_nxt;
            cyc_slow_r <= cyc_slow_nxt;
            cyc_word_r <= cyc_word_nxt;
            cyc_wr_r <= cyc_wr_nxt;
            split_r <= split_nxt;
            done_r <= done_nxt;
            ext_r <= ext_nxt;
            addr_r <= addr_nxt;
            dhi_r <= dhi_nxt;
            dlo_r <= dlo_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign cpu_done = done_r;
    assign cpu_ext = ext_r;
    assign cpu_rdata = rdat_r;
    assign ext_addr = addr_r;
    assign data_hi_out = dhi_r;
    assign data_lo_out = dlo_r;

    ebac_lane_map u_lane (
        .busy      (st_r != ST_IDLE),
        .strobe_ph (st_r == ST_T2 || st_r == ST_T3),
        .write     (cyc_wr_r),
        .wide      (cyc_wide_r),
        .word      (cyc_word_r),
        .a0        (addr_r[0]),
        .hi_oe     (data_hi_oe),
        .lo_oe     (data_lo_oe),
        .rd_n      (rd_n),
        .hwr_n     (high_byte_write_strobe_n),
        .lwr_n     (low_byte_write_strobe_n)
    );

    ////////////////////////////////////////////////////////////////////
    property p_two_state;
        @(posedge mclk) disable iff (!rst_n)
        (st_r == ST_T1 && !cyc_slow_r) |=> (st_r == ST_T2) ##1 (st_r != ST_T3);
    endproperty
    a_two_state: assert property (p_two_state) else $error("two-state length");

    property p_three_state;
        @(posedge mclk) disable iff (!rst_n)
        (st_r == ST_T1 && cyc_slow_r) |=> (st_r == ST_T2) ##1 (st_r == ST_T3);
    endproperty
    a_three_state: assert property (p_three_state) else $error("three-state length");

    property p_attr_hold;
        @(posedge mclk) disable iff (!rst_n)
        (st_r == ST_T2 || st_r == ST_T3) |-> $stable(cyc_wide_r) && $stable(cyc_slow_r);
    endproperty
    a_attr_hold: assert property (p_attr_hold) else $error("attributes moved");

    property p_narrow_lane;
        @(posedge mclk) disable iff (!rst_n)
        (st_r != ST_IDLE && !cyc_wide_r) |-> !data_lo_oe && low_byte_write_strobe_n;
    endproperty
    a_narrow_lane: assert property (p_narrow_lane) else $error("low lane in byte area");

    property p_mode2_lane;
        @(posedge mclk) disable iff (!rst_n)
        (init_r && mode_r == MODE2) |-> !data_lo_oe && low_byte_write_strobe_n;
    endproperty
    a_mode2_lane: assert property (p_mode2_lane) else $error("mode 2 low lane used");

    property p_split;
        @(posedge mclk) disable iff (!rst_n)
        (st_r == ST_T1 && split_r) |-> ##[2:3] (st_r == ST_T1 && addr_r[0]);
    endproperty
    a_split: assert property (p_split) else $error("odd byte cycle missing");

    property p_area_off;
        @(posedge mclk) disable iff (!rst_n)
        (start && dec_ext && !ctl_r[CTL_AREA_ON]) |=> (!cyc_wide_r && cyc_slow_r);
    endproperty
    a_area_off: assert property (p_area_off) else $error("area control off not byte");

    property p_no_byte_fast;
        @(posedge mclk) disable iff (!rst_n)
        (st_r == ST_T1) |-> (cyc_wide_r || cyc_slow_r);
    endproperty
    a_no_byte_fast: assert property (p_no_byte_fast) else $error("byte two-state seen");

    property p_mode7_quiet;
        @(posedge mclk) disable iff (!rst_n)
        (init_r && mode_r == MODE7) |-> (st_r == ST_IDLE) && rd_n;
    endproperty
    a_mode7_quiet: assert property (p_mode7_quiet) else $error("mode 7 bus cycle");

    property p_zero_page;
        @(posedge mclk) disable iff (!rst_n)
        (start && dec_ext && ctl_r[CTL_ZP_SLOW] && req_addr[19:16] == 4'h0)
        |=> cyc_slow_r;
    endproperty
    a_zero_page: assert property (p_zero_page) else $error("page 0 not slow");
endmodule
`default_nettype wire

// File: verif/ebac_mem_model.sv
// ebac_mem_model: external memory on the split data lanes.
// assumes active-low strobes and a registered ext_addr.
`default_nettype none
module ebac_mem_model (
    input  wire logic        mclk,
    input  wire logic [19:0] ext_addr,
    input  wire logic [7:0]  data_hi_out,
    input  wire logic        rd_n,
    input  wire logic        hi_wr_n,
    input  wire logic        lo_wr_n,
    output logic      [15:0] data_in,
    output logic      [7:0]  last_hi,
    output int               lo_writes
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] held = 16'h0000;
    int          cnt  = 0;
    // released bus shows the inverse, so a late sample cannot pass
    assign data_in = !rd_n ? {ext_addr[7:0] ^ 8'h5a, (ext_addr[7:0] | 8'h01) ^ 8'h5a} : ~held;
    assign lo_writes = cnt;
    always @(posedge mclk) begin
        if (!rd_n)
            held <= data_in;
        if (!hi_wr_n)
            last_hi <= data_hi_out;
        if (!lo_wr_n)
            cnt <= cnt + 1;
    end
endmodule
`default_nettype wire

// File: verif/ebac_ctl_tb.sv
// ebac_ctl_tb: self-checking bench for ebac_ctl.
// assumes the reset area map of each mode strap.
`default_nettype none
module ebac_ctl_tb
    import ebac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_n = 0, hsel = 0, hwrite = 0, cpu_req = 0, cpu_write = 0;
    logic cpu_word = 0;
    logic hreadyout, cpu_done, cpu_ext, rd_n, hwn, lwn;
    logic [2:0] mode = 3'h1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d, v;
    logic [31:0] rs = 32'h0000146d;
    logic [19:0] cpu_addr = 20'h0, ext_addr;
    logic [15:0] cpu_wdata = 16'h0, cpu_rdata, data_in;
    logic [7:0] dho, last_hi;
    int miscompares = 0, tests_run = 0, lo_writes, ticks = 0, n;
    logic [31:0] slow_rst [1:7] = '{32'hee00, 32'hee80, 32'he000, 32'hee80, 0, 0, 32'h100000};
    // edges from take to the edge that sees cpu_done: on-chip 2, two-state 4, three-state 5
    int lo_cyc [1:7] = '{4, 2, 4, 2, 5, 5, 2};
    logic lo_ext [1:7] = '{1, 0, 1, 0, 1, 1, 0};
    ebac_ctl dut (.mclk(mclk), .rst_n(rst_n), .mode(mode), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .cpu_req(cpu_req),
        .cpu_addr(cpu_addr), .cpu_word(cpu_word), .cpu_write(cpu_write), .cpu_wdata(cpu_wdata),
        .cpu_done(cpu_done), .cpu_ext(cpu_ext), .cpu_rdata(cpu_rdata), .ext_addr(ext_addr),
        .data_hi_out(dho), .data_hi_oe(), .data_lo_out(), .data_lo_oe(), .data_in(data_in),
        .rd_n(rd_n), .high_byte_write_strobe_n(hwn), .low_byte_write_strobe_n(lwn));
    ebac_mem_model mem (.mclk(mclk), .ext_addr(ext_addr), .data_hi_out(dho), .rd_n(rd_n),
        .hi_wr_n(hwn), .lo_wr_n(lwn), .data_in(data_in), .last_hi(last_hi),
        .lo_writes(lo_writes));
    always #2.5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a);
        @(posedge mclk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    task automatic acc(input logic wr, wd, input logic [19:0] a, input int cyc, input logic ext);
        logic [15:0] er;
        v = xs();
        er = wd ? {a[7:0] ^ 8'h5a, (a[7:0] | 8'h01) ^ 8'h5a} : {8'h00, a[7:0] ^ 8'h5a};
        @(posedge mclk);
        cpu_req <= 1;
        cpu_word <= wd;
        cpu_write <= wr;
        cpu_addr <= a;
        cpu_wdata <= v[15:0];
        // first pass is the take edge; cpu_done is read as it stood before each edge
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (cpu_done !== 1'b1 && n < 20);
        cpu_req <= 0;
        check("cycles", cyc, n);
        check("cpu_ext", ext, cpu_ext);
        if (ext && !wr)
            check("rdata", er, cpu_rdata);
        if (ext && wr)
            check("hi_lane", v[7:0], last_hi);
    endtask
    always @(posedge mclk) begin
        ticks++;
        if (ticks == 20000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        for (int m = 1; m <= 7; m++) begin
            rst_n <= 0;
            mode <= m[2:0];
            repeat (20) @(posedge mclk);
            rst_n <= 1;
            repeat (2) @(posedge mclk);
            ahb(0, OFS_SLOW_BND);
            check("slow_bnd", slow_rst[m], d);
            acc(0, 0, 20'h01000, lo_cyc[m], lo_ext[m]);
            if (m != 7)
                acc(1, 0, 20'h0f000, 5, 1);
            if (m == 2 || m == 6) begin
                acc(1, 1, 20'h0f000, 8, 1);
                acc(0, 1, 20'h0f002, 8, 1);
            end
            if (m == 1) begin
                d = 32'h000000de;
                ahb(1, OFS_BUS_CTL);
                ahb(0, OFS_BUS_CTL);
                check("bus_ctl", 32'h000000fe, d);
                acc(0, 0, 20'h01000, 5, 1);
                acc(0, 0, 20'h0fe80, 5, 1);
                acc(0, 0, 20'h0f680, 2, 0);
            end
            if (m == 3) begin
                d = 32'h1000;
                ahb(1, OFS_SLOW_BND);
                acc(0, 0, 20'h01000, 5, 1);
                acc(0, 0, 20'h00ffe, 4, 1);
                d = 32'hffffffff;
                ahb(0, 8'h20);
                check("unmapped", 32'h0, d);
            end
        end
        check("lo_writes", 0, lo_writes);
        conclude();
    end
endmodule
`default_nettype wire
